// file: common/cmd_status_pkg.sv
/*
 Constants for the function command/status register pair.
 Assumes users reference every name as cmd_status_pkg::name.
*/
package cmd_status_pkg;
	localparam logic [7:0] cmd_status_offset = 8'h04;
	localparam logic [7:0] cap_ptr_offset    = 8'h34;
	localparam int io_enable_bit    = 0;
	localparam int mem_enable_bit   = 1;
	localparam int bus_master_bit   = 2;
	localparam int parity_resp_bit  = 6;
	localparam int system_error_report_enable_bit  = 8;
	localparam int int_disable_bit  = 10;
	localparam int int_status_bit   = 19;
	localparam int cap_list_bit     = 20;
	localparam int target_abort_bit = 27;
	localparam int sys_error_bit    = 30;
	localparam int parity_det_bit   = 31;
	localparam logic [15:0] cmd_writable_mask = 16'h0543;
	localparam logic [15:0] cmd_reset         = 16'h0000;
	localparam logic [2:0]  flags_reset       = 3'h0;
	localparam logic        cap_list_reset    = 1'h1;
	localparam logic        bus_master_reset  = 1'h0;
endpackage

// file: tb/cfg_requester.sv
/* Root complex model issuing configuration reads and writes.
 Assumes the port takes requests at the rising edge of mclk. */
`timescale 1ns/1ns
module cfg_requester (
	// Clock.
	input  wire logic        mclk,
	// Requests.
	output logic             cfg_read,
	output logic             cfg_write,
	output logic      [7:0]  cfg_offset,
	output logic      [3:0]  cfg_byte_en,
	output logic      [31:0] cfg_wdata,
	// Answers.
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_rvalid
);
	initial begin
		cfg_read = 1'b0;
		cfg_write = 1'b0;
		cfg_offset = 8'h00;
		cfg_byte_en = 4'h0;
		cfg_wdata = 32'h0;
	end
	task automatic wr(input logic [7:0] o, input logic [3:0] b, input logic [31:0] w);
		@(negedge mclk);
		{cfg_write, cfg_offset, cfg_byte_en, cfg_wdata} = {1'b1, o, b, w};
		@(negedge mclk);
		cfg_write = 1'b0;
		// Idle data is inverted so a stale write cannot match by luck.
		cfg_wdata = ~w;
	endtask
	task automatic rd(input logic [7:0] o, output logic [31:0] r);
		int i;
		r = 'x;
		i = 0;
		@(negedge mclk);
		{cfg_read, cfg_offset} = {1'b1, o};
		@(negedge mclk);
		cfg_read = 1'b0;
		while (cfg_rvalid !== 1'b1 && i < 4) begin
			@(negedge mclk);
			i++;
		end
		if (cfg_rvalid === 1'b1) r = cfg_rdata;
	endtask
endmodule

// file: tb/cmd_status_asserts.sv
/* Assertions on the command/status register pair.
 Assumes it is bound to function_cmd_status. */
`timescale 1ns/1ns
module cmd_status_asserts (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        cfg_read,
	input wire logic [7:0]  cfg_offset,
	input wire logic [31:0] cfg_rdata,
	input wire logic        cfg_rvalid,
	input wire logic        io_request,
	input wire logic        mem_request,
	input wire logic        io_claim,
	input wire logic        mem_claim,
	input wire logic        bus_master_en,
	input wire logic        error_detected,
	input wire logic        error_message,
	input wire logic        int_pending,
	input wire logic        intx_assert
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_IO: assert property (io_claim |-> $past(io_request)) else $error("io claim");
	AST_MEM: assert property (mem_claim |-> $past(mem_request)) else $error("mem");
	AST_BM: assert property (!bus_master_en) else $error("bus master");
	AST_CMD0: assert property (cfg_rvalid |-> !(cfg_rdata & 32'h0000_fab8)) else $error("cmd");
	AST_STAT0: assert property (cfg_rvalid |-> !(cfg_rdata & 32'h37e7_0000)) else $error("st");
	AST_CAP: assert property (cfg_read && cfg_offset == 8'h04 |=> cfg_rvalid && cfg_rdata[20])
		else $error("cap list");
	AST_ERR: assert property (error_message |-> $past(error_detected)) else $error("err");
	AST_INTX: assert property (intx_assert |-> $past(int_pending)) else $error("intx");
	cover property (io_claim && mem_claim);
	cover property (intx_assert);
	cover property (error_message);
endmodule
bind function_cmd_status cmd_status_asserts chk (.mclk(mclk), .rst_b(rst_b),
	.cfg_read(cfg_read), .cfg_offset(cfg_offset), .cfg_rdata(cfg_rdata),
	.cfg_rvalid(cfg_rvalid), .io_request(io_request), .mem_request(mem_request),
	.io_claim(io_claim), .mem_claim(mem_claim), .bus_master_en(bus_master_en),
	.error_detected(error_detected), .error_message(error_message),
	.int_pending(int_pending), .intx_assert(intx_assert));

// file: tb/tb.sv
/* Self-checking bench for the command/status register pair.
 Assumes cfg_requester drives the configuration port. */
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
	logic mclk = 0, rst_b = 0, int_pending = 0, completer_abort = 0;
	logic error_detected = 0, poisoned_tlp = 0, io_request = 0, mem_request = 0;
	logic cfg_read, cfg_write, cfg_rvalid, io_claim, mem_claim, bus_master_en;
	logic parity_resp_en, error_message, intx_assert;
	logic [7:0] cfg_offset;
	logic [3:0] cfg_byte_en;
	logic [31:0] cfg_wdata, cfg_rdata, d;
	int num_errors = 0, samples_checked = 0;
	always #50 mclk = ~mclk;
	cfg_requester rc (.mclk(mclk), .cfg_read(cfg_read), .cfg_write(cfg_write),
		.cfg_offset(cfg_offset), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
	function_cmd_status dut (.mclk(mclk), .rst_b(rst_b), .cfg_read(cfg_read),
		.cfg_write(cfg_write), .cfg_offset(cfg_offset), .cfg_byte_en(cfg_byte_en),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.int_pending(int_pending), .completer_abort(completer_abort),
		.error_detected(error_detected), .poisoned_tlp(poisoned_tlp),
		.io_request(io_request), .mem_request(mem_request), .io_claim(io_claim),
		.mem_claim(mem_claim), .bus_master_en(bus_master_en),
		.parity_resp_en(parity_resp_en), .error_message(error_message),
		.intx_assert(intx_assert));
	task rd_chk(input logic [31:0] e);
		rc.rd(8'h04, d);
		`CHK("cmd_status", e, d)
	endtask
	task t_cmd();
		rd_chk(32'h0010_0000);
		rc.wr(8'h04, 4'h3, 32'hffff_ffff);
		rd_chk(32'h0010_0543);
		`CHK("parity_resp", 1'b1, parity_resp_en)
		`CHK("bus_master", 1'b0, bus_master_en)
		rc.wr(8'h08, 4'hf, 32'h0);
		rc.rd(8'h08, d);
		`CHK("unmapped", 32'h0, d)
		rd_chk(32'h0010_0543);
	endtask
	task t_claim();
		{io_request, mem_request} = 2'b11;
		@(negedge mclk);
		`CHK("io_claim", 1'b1, io_claim)
		`CHK("mem_claim", 1'b1, mem_claim)
		rc.wr(8'h04, 4'h3, 32'h0400);
		@(negedge mclk);
		`CHK("io_claim", 1'b0, io_claim)
		`CHK("mem_claim", 1'b0, mem_claim)
		{io_request, mem_request} = 2'b00;
	endtask
	task t_intx();
		int_pending = 1'b1;
		@(negedge mclk);
		`CHK("intx", 1'b0, intx_assert)
		rd_chk(32'h0018_0400);
		rc.wr(8'h04, 4'h3, 32'h0);
		@(negedge mclk);
		`CHK("intx", 1'b1, intx_assert)
		rc.wr(8'h04, 4'h3, 32'h0400);
		@(negedge mclk);
		`CHK("intx", 1'b0, intx_assert)
		rd_chk(32'h0018_0400);
		int_pending = 1'b0;
	endtask
	task t_flags();
		rc.wr(8'h04, 4'h3, 32'h0100);
		{completer_abort, error_detected, poisoned_tlp} = 3'b111;
		@(negedge mclk);
		{completer_abort, error_detected, poisoned_tlp} = 3'b000;
		`CHK("error_message", 1'b1, error_message)
		@(negedge mclk);
		rd_chk(32'hc810_0100);
		rc.wr(8'h04, 4'h8, 32'h4000_0000);
		rd_chk(32'h8810_0100);
		rc.wr(8'h04, 4'hc, 32'hffff_0000);
		rd_chk(32'h0010_0100);
		rc.wr(8'h04, 4'h3, 32'h0);
		error_detected = 1'b1;
		@(negedge mclk);
		error_detected = 1'b0;
		repeat (2) @(negedge mclk);
		rd_chk(32'h0010_0000);
	endtask
	task test_done();
		if (num_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
		t_cmd();
		t_claim();
		t_intx();
		t_flags();
		test_done();
	end
	// Cuts a hung run short well past the normal sequence length.
	initial begin
		#500000;
		num_errors++;
		test_done();
	end
endmodule

// file: verilog/function_cmd_status.sv
/*
 Command and status register pair of one host-controller function,
 reached by configuration reads and writes of dword offset 04h.
 Assumes the configuration port and all event pulses are on mclk.
*/
// Contract
// - I/O requests claimed only while command bit 0 is set; resets zero.
// - Memory requests claimed only while command bit 1 is set; resets zero.
// - Bus-master enable bit 2 is read-only, resets zero, gates mastering.
// - Command bits 3,4,5,7,9 read zero always.
// - Bit 6 parity response enable; parity errors still set status flag.
// - Bit 8 enables reporting fatal and non-fatal errors to root.
// - Bit 10 interrupt disable, writable, resets zero.
// - Status bit 19 shows pending interrupt regardless of disable.
// - Status bit 20 reads one: capability list at offset 34h.
// - Status bits 21, 23, 26:25 read zero.
// - Status bits 24, 28, 29 read zero; writes ignored.
// - Bit 27 set when a request completes with completer abort.
// - Bit 30 set on error message sent while reporting enabled.
// - Bit 31 set on received poisoned TLP.
`timescale 1ns/1ns
module function_cmd_status (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// Configuration access.
	input  wire logic        cfg_read,
	input  wire logic        cfg_write,
	input  wire logic [7:0]  cfg_offset,
	input  wire logic [3:0]  cfg_byte_en,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	output logic             cfg_rvalid,
	// Function events.
	input  wire logic        int_pending,
	input  wire logic        completer_abort,
	input  wire logic        error_detected,
	input  wire logic        poisoned_tlp,
	// Decode and request controls.
	input  wire logic        io_request,
	input  wire logic        mem_request,
	output logic             io_claim,
	output logic             mem_claim,
	output logic             bus_master_en,
	output logic             parity_resp_en,
	output logic             error_message,
	output logic             intx_assert
);
	logic [15:0] cmd_reg;
	logic [15:0] cmd_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        rvalid_reg;
	logic        io_claim_reg;
	logic        mem_claim_reg;
	logic        err_msg_reg;
	logic        err_msg_next;
	logic        bus_master_reg;
	logic        hit;
	logic [2:0]  set_pulse;
	logic [2:0]  clear_mask;
	logic [2:0]  flags;
	logic        int_status;
	logic        intx_int;
	logic [31:0] reg_value;
	logic        wr_hit;
	logic        rd_hit;
	logic [3:0]  lane_we;
	logic [15:0] cmd_wdata;
	logic [15:0] cmd_lane_mask;
	logic [15:0] cmd_bits;
	logic        rvalid_next;
	logic        io_claim_next;
	logic        mem_claim_next;
	logic        bus_master_next;

	function automatic logic [7:0] lane(input logic [31:0] d, input logic [3:0] be,
		input int idx);
		lane = be[idx] ? d[idx*8 +: 8] : 8'h00;
	endfunction

	// Only the command/status dword decodes here. Every other offset belongs to the
	// neighbouring header logic, which is why a miss simply reads back zero.
	assign hit = (cfg_offset == cmd_status_pkg::cmd_status_offset);

	always_comb begin
		wr_hit  = cfg_write & hit;
		rd_hit  = cfg_read & hit;
		lane_we = wr_hit ? cfg_byte_en : 4'h0;
	end

	always_comb begin
		// Byte lanes 0 and 1 carry the command half of the dword.
		cmd_wdata     = {lane(cfg_wdata, lane_we, 1), lane(cfg_wdata, lane_we, 0)};
		cmd_lane_mask = {{8{lane_we[1]}}, {8{lane_we[0]}}} & cmd_status_pkg::cmd_writable_mask;
		cmd_next      = cmd_reg;
		if (wr_hit) begin
			cmd_next = (cmd_wdata & cmd_lane_mask) | (cmd_reg & ~cmd_lane_mask);
		end
	end

	always_comb begin
		clear_mask = 3'h0;
		if (lane_we[3]) begin
			clear_mask = {cfg_wdata[cmd_status_pkg::parity_det_bit],
				cfg_wdata[cmd_status_pkg::sys_error_bit],
				cfg_wdata[cmd_status_pkg::target_abort_bit]};
		end
	end

	always_comb begin
		err_msg_next = error_detected & cmd_reg[cmd_status_pkg::system_error_report_enable_bit];
		set_pulse = {poisoned_tlp, err_msg_reg, completer_abort};
	end

	always_comb begin
		// Hardwired command bits never leave the writable mask.
		cmd_bits = cmd_reg & cmd_status_pkg::cmd_writable_mask;
		cmd_bits[cmd_status_pkg::bus_master_bit] = bus_master_reg;
		// Status bits start at zero; only live ones are filled in.
		reg_value = 32'h0000_0000;
		reg_value[15:0] = cmd_bits;
		reg_value[cmd_status_pkg::int_status_bit] = int_status;
		reg_value[cmd_status_pkg::cap_list_bit] = cmd_status_pkg::cap_list_reset;
		reg_value[cmd_status_pkg::target_abort_bit] = flags[0];
		reg_value[cmd_status_pkg::sys_error_bit] = flags[1];
		reg_value[cmd_status_pkg::parity_det_bit] = flags[2];
	end

	// Read data is held between reads, so a slow requester can still pick it up.
	always_comb begin
		rdata_next = rdata_reg;
		if (cfg_read) begin
			// Unmapped offsets read zero; other header registers live elsewhere.
			rdata_next = rd_hit ? reg_value : 32'h0000_0000;
		end
	end

	always_comb begin
		rvalid_next     = cfg_read;
		io_claim_next   = io_request & cmd_reg[cmd_status_pkg::io_enable_bit];
		mem_claim_next  = mem_request & cmd_reg[cmd_status_pkg::mem_enable_bit];
		// Mastering stays off: the enable is read-only and never set.
		bus_master_next = cmd_status_pkg::bus_master_reset;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_reg        <= cmd_status_pkg::cmd_reset;
			rdata_reg      <= 32'h0000_0000;
			rvalid_reg     <= 1'h0;
			io_claim_reg   <= 1'h0;
			mem_claim_reg  <= 1'h0;
			err_msg_reg    <= 1'h0;
			bus_master_reg <= cmd_status_pkg::bus_master_reset;
		end else begin
			cmd_reg        <= cmd_next;
			rdata_reg      <= rdata_next;
			rvalid_reg     <= rvalid_next;
			io_claim_reg   <= io_claim_next;
			mem_claim_reg  <= mem_claim_next;
			err_msg_reg    <= err_msg_next;
			bus_master_reg <= bus_master_next;
		end
	end

	status_flags u_flags (
		.mclk       (mclk),
		.rst_b      (rst_b),
		.set_pulse  (set_pulse),
		.clear_mask (clear_mask),
		.flags      (flags)
	);

	intx_gate u_intx (
		.mclk        (mclk),
		.rst_b       (rst_b),
		.int_pending (int_pending),
		.int_disable (cmd_reg[cmd_status_pkg::int_disable_bit]),
		.int_status  (int_status),
		.intx_assert (intx_int)
	);

	assign cfg_rdata      = rdata_reg;
	assign cfg_rvalid     = rvalid_reg;
	assign io_claim       = io_claim_reg;
	assign mem_claim      = mem_claim_reg;
	assign bus_master_en  = bus_master_reg;
	assign parity_resp_en = cmd_reg[cmd_status_pkg::parity_resp_bit];
	assign error_message  = err_msg_reg;
	assign intx_assert    = intx_int;
endmodule

// file: verilog/intx_gate.sv
/*
 Holds the internal interrupt-pending level and the gated INTx request.
 Assumes the pending source is synchronous to mclk.
*/
`timescale 1ns/1ns
module intx_gate (
	// Clock and reset.
	input  wire logic mclk,
	input  wire logic rst_b,
	// Controls.
	input  wire logic int_pending,
	input  wire logic int_disable,
	// Results.
	output logic      int_status,
	output logic      intx_assert
);
	logic int_status_reg;
	logic int_status_next;
	logic intx_reg;
	logic intx_next;

	always_comb begin
		int_status_next = int_pending;
		intx_next = int_pending & ~int_disable;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			int_status_reg <= 1'h0;
			intx_reg       <= 1'h0;
		end else begin
			int_status_reg <= int_status_next;
			intx_reg       <= intx_next;
		end
	end

	assign int_status  = int_status_reg;
	assign intx_assert = intx_reg;
endmodule

// file: verilog/status_flags.sv
/*
 Three sticky status flags, each cleared by writing one.
 Assumes set pulses and the clear mask arrive on mclk.
*/
`timescale 1ns/1ns
module status_flags (
	// Clock and reset.
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Events and software clear.
	input  wire logic [2:0] set_pulse,
	input  wire logic [2:0] clear_mask,
	// Flags.
	output logic      [2:0] flags
);
	logic [2:0] flags_reg;
	logic [2:0] flags_next;

	always_comb begin
		// Set wins over a clear in the same cycle so no event is lost.
		flags_next = (flags_reg & ~clear_mask) | set_pulse;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flags_reg <= cmd_status_pkg::flags_reset;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags = flags_reg;
endmodule
